// ---- core/rscr_pkg.sv ----
// package for the reference and sequencer control register bank
// assumes an 8-bit register port with a 15-bit address, single clock domain
package rscr_pkg;

    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [14:0] REF_CFG_ADDR = 15'h0021;
    localparam logic [14:0] SEQ_CFG_ADDR = 15'h0022;
    localparam logic [7:0]  REF_CFG_RST  = 8'h12;
    localparam logic [7:0]  SEQ_CFG_RST  = 8'h80;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int CLAMP_POLICY_BIT = 7;
    localparam int BYPASS_BIT       = 6;
    localparam int BOOST_BIT        = 5;
    localparam int RANGE_MSB        = 4;
    localparam int RANGE_LSB        = 2;
    localparam int HIZ_BIT          = 1;
    localparam int VBUF_EN_BIT      = 0;
    localparam int STD_SEQ_BIT      = 7;
    localparam int SLOT_MSB         = 6;

    localparam logic [2:0] RANGE_RST    = 3'h4;
    localparam logic [2:0] RANGE_MAX    = 3'h4;
    localparam logic [6:0] SLOT_CNT_RST = 7'h00;

    // ************************************************************
    // carriers
    // ************************************************************
    typedef struct packed {
        logic [14:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } rscr_req_t;

    typedef struct packed {
        logic       clamp_current_policy;
        logic       vbuffer_bypass_active;
        logic       vbuffer_boost_active;
        logic       vbuffer_enable_active;
        logic [2:0] reference_range;
        logic       reference_high_impedance_enable;
        logic       standard_sequencer_enable;
        logic [6:0] advanced_slot_count_minus_one;
        logic [7:0] advanced_slot_total;
    } rscr_ctrl_t;

endpackage

// ---- core/rscr_reg8.sv ----
// one 8-bit read/write register with a constant reset value
// assumes write enable already decoded on the same clock
`timescale 1ns/100ps
module rscr_reg8 #(
    parameter logic [7:0] RST = 8'h00
) (
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       resetn,
    // write side
    input  wire logic       wen,
    input  wire logic [7:0] wdata,
    // stored value
    output logic      [7:0] q
);
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            q <= RST;
        else if (wen)
            q <= wdata;
    end
endmodule // rscr_reg8

// ---- core/rscr_decode.sv ----
// turns the stored register values into the control levels the analog units see
// assumes package variant strap is already stable and synchronised
`timescale 1ns/100ps
module rscr_decode (
    // stored registers
    input  wire logic [7:0]          ref_q,
    input  wire logic [7:0]          seq_q,
    // package variant
    input  wire logic                chip_scale_package_variant,
    // decoded controls
    output rscr_pkg::rscr_ctrl_t     next_ctrl
);
    always_comb
    begin
        next_ctrl.clamp_current_policy = ref_q[rscr_pkg::CLAMP_POLICY_BIT];
        // buffer bits are dead on the lead-frame variant
        next_ctrl.vbuffer_enable_active = chip_scale_package_variant
                                          & ref_q[rscr_pkg::VBUF_EN_BIT];
        // enabled buffer forces the bypass switch open
        next_ctrl.vbuffer_bypass_active = chip_scale_package_variant & ref_q[rscr_pkg::BYPASS_BIT]
                                          & ~ref_q[rscr_pkg::VBUF_EN_BIT];
        next_ctrl.vbuffer_boost_active = chip_scale_package_variant
                                         & ref_q[rscr_pkg::BOOST_BIT];
        next_ctrl.reference_range = ref_q[rscr_pkg::RANGE_MSB:rscr_pkg::RANGE_LSB];
        next_ctrl.reference_high_impedance_enable = ref_q[rscr_pkg::HIZ_BIT];
        next_ctrl.standard_sequencer_enable = seq_q[rscr_pkg::STD_SEQ_BIT];
        next_ctrl.advanced_slot_count_minus_one = seq_q[rscr_pkg::SLOT_MSB:0];
        next_ctrl.advanced_slot_total = {1'b0, seq_q[rscr_pkg::SLOT_MSB:0]} + 8'h01;
    end
endmodule // rscr_decode

// ---- core/rscr_regs.sv ----
// reference and sequencer configuration register bank, top level
// assumes a same-clock register port master; read data one cycle after the read strobe
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/100ps

// Notes on behaviour
// - reference configuration register at 0x0021, 8 bits, resets to 0x12
// - bit 7: 0 lowers reference current during clamping, 1 leaves it
// - bit 6 bypasses buffer, ignored while buffer enable is 1
// - bit 5 enables buffer boost mode, resets to 0
// - bypass, boost, enable act only on chip-scale variant; stored anyway
// - bits 4:2 reference range code, codes 0 to 4, resets to 4
// - bit 1 enables reference input high-impedance mode, resets to 1
// - bit 0 enables buffer, resets to 0, forces bypass switch open
// - sequencer configuration register at 0x0022, 8 bits, resets to 0x80
// - bit 7 enables standard sequencer, resets to 1
// - bits 6:0 advanced slot field; slot count is field plus one
module rscr_regs (
    // clock and reset
    input  wire logic                 sys_clk,
    input  wire logic                 resetn,
    // register port
    input  wire rscr_pkg::rscr_req_t  req,
    output logic      [7:0]           rdata,
    // package variant strap, from a pin
    input  wire logic                 chip_scale_package_variant,
    // controls to the analog and sequencer units
    output rscr_pkg::rscr_ctrl_t      ctrl,
    // range code outside the documented set
    output logic                      range_code_invalid
);

    // ************************************************************
    // strap synchroniser
    // ************************************************************
    logic variant_meta;
    logic variant_sync;

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            variant_meta <= 1'b0;
            variant_sync <= 1'b0;
        end
        else
        begin
            variant_meta <= chip_scale_package_variant;
            variant_sync <= variant_meta;
        end
    end

    // ************************************************************
    // write decode and storage
    // ************************************************************
    logic       ref_wen;
    logic       seq_wen;
    logic [7:0] ref_q;
    logic [7:0] seq_q;

    always_comb
    begin
        ref_wen = 1'b0;
        seq_wen = 1'b0;
        if (req.wr && req.addr == rscr_pkg::REF_CFG_ADDR)
            ref_wen = 1'b1;
        else if (req.wr && req.addr == rscr_pkg::SEQ_CFG_ADDR)
            seq_wen = 1'b1;
    end

    rscr_reg8 #(
        .RST   (rscr_pkg::REF_CFG_RST)
    ) u_ref (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .wen     (ref_wen),
        .wdata   (req.wdata),
        .q       (ref_q)
    );

    rscr_reg8 #(
        .RST   (rscr_pkg::SEQ_CFG_RST)
    ) u_seq (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .wen     (seq_wen),
        .wdata   (req.wdata),
        .q       (seq_q)
    );

    // ************************************************************
    // read path
    // ************************************************************
    logic [7:0] next_rdata;

    always_comb
    begin
        // unmapped addresses read as zero
        next_rdata = 8'h00;
        if (req.addr == rscr_pkg::REF_CFG_ADDR)
            next_rdata = ref_q;
        else if (req.addr == rscr_pkg::SEQ_CFG_ADDR)
            next_rdata = seq_q;
    end

    // data stands for one cycle only, zero otherwise
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            rdata <= 8'h00;
        else if (req.rd)
            rdata <= next_rdata;
        else
            rdata <= 8'h00;
    end

    // ************************************************************
    // control outputs
    // ************************************************************
    rscr_pkg::rscr_ctrl_t next_ctrl;

    rscr_decode u_dec (
        .ref_q                      (ref_q),
        .seq_q                      (seq_q),
        .chip_scale_package_variant (variant_sync),
        .next_ctrl                  (next_ctrl)
    );

    // registered so analog controls never glitch; one cycle behind storage
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ctrl.clamp_current_policy            <= 1'b0;
            ctrl.vbuffer_bypass_active           <= 1'b0;
            ctrl.vbuffer_boost_active            <= 1'b0;
            ctrl.vbuffer_enable_active           <= 1'b0;
            ctrl.reference_range                 <= rscr_pkg::RANGE_RST;
            ctrl.reference_high_impedance_enable <= 1'b1;
            ctrl.standard_sequencer_enable       <= 1'b1;
            ctrl.advanced_slot_count_minus_one   <= rscr_pkg::SLOT_CNT_RST;
            ctrl.advanced_slot_total             <= 8'h01;
        end
        else
            ctrl <= next_ctrl;
    end

    // software's duty to pick a valid code; flag it rather than guess
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            range_code_invalid <= 1'b0;
        else
            range_code_invalid <= next_ctrl.reference_range > rscr_pkg::RANGE_MAX;
    end

    // ************************************************************
    // assertions
    // ************************************************************
    a_ref_readback: assert property (@(posedge sys_clk) disable iff (!resetn)
        req.wr && req.addr == rscr_pkg::REF_CFG_ADDR ##1 req.rd && req.addr == rscr_pkg::REF_CFG_ADDR
        |=> rdata == $past(req.wdata, 2))
        else $error("reference register read back differs from write");

    a_seq_readback: assert property (@(posedge sys_clk) disable iff (!resetn)
        req.wr && req.addr == rscr_pkg::SEQ_CFG_ADDR ##1 req.rd && req.addr == rscr_pkg::SEQ_CFG_ADDR
        |=> rdata == $past(req.wdata, 2))
        else $error("sequencer register read back differs from write");

    a_bypass_blocked: assert property (@(posedge sys_clk) disable iff (!resetn)
        ref_q[rscr_pkg::VBUF_EN_BIT] |=> !ctrl.vbuffer_bypass_active)
        else $error("bypass active while buffer enabled");

    a_lead_frame_dead: assert property (@(posedge sys_clk) disable iff (!resetn)
        !variant_sync |=> !ctrl.vbuffer_boost_active && !ctrl.vbuffer_enable_active
                          && !ctrl.vbuffer_bypass_active)
        else $error("buffer controls active on lead-frame variant");

    a_boost_follows: assert property (@(posedge sys_clk) disable iff (!resetn)
        variant_sync && ref_wen && req.wdata[rscr_pkg::BOOST_BIT] ##1 variant_sync
        |=> ctrl.vbuffer_boost_active)
        else $error("boost not applied after write");

    a_slot_total: assert property (@(posedge sys_clk) disable iff (!resetn)
        ctrl.advanced_slot_total == {1'b0, ctrl.advanced_slot_count_minus_one} + 8'h01)
        else $error("slot total not field plus one");

    a_range_follows: assert property (@(posedge sys_clk) disable iff (!resetn)
        ref_wen |=> ##1 ctrl.reference_range == $past(req.wdata[4:2], 2))
        else $error("range code not applied");

    a_clamp_follows: assert property (@(posedge sys_clk) disable iff (!resetn)
        ##1 ctrl.clamp_current_policy == $past(ref_q[7]))
        else $error("clamp policy mismatch");

    a_hiz_follows: assert property (@(posedge sys_clk) disable iff (!resetn)
        ##1 ctrl.reference_high_impedance_enable == $past(ref_q[1]))
        else $error("high impedance enable mismatch");

    a_stdseq_follows: assert property (@(posedge sys_clk) disable iff (!resetn)
        ##1 ctrl.standard_sequencer_enable == $past(seq_q[7]))
        else $error("standard sequencer enable mismatch");

    a_unmapped_zero: assert property (@(posedge sys_clk) disable iff (!resetn)
        req.rd && req.addr != rscr_pkg::REF_CFG_ADDR && req.addr != rscr_pkg::SEQ_CFG_ADDR
        |=> rdata == 8'h00)
        else $error("unmapped read not zero");

    // ************************************************************
    // storage and read port
    // ************************************************************
    a_ref_write_lands: assert property (@(posedge sys_clk) disable iff (!resetn)
        ref_wen
        |=> ref_q == $past(req.wdata))
        else $error("reference register did not take the write");

    a_seq_write_lands: assert property (@(posedge sys_clk) disable iff (!resetn)
        seq_wen
        |=> seq_q == $past(req.wdata))
        else $error("sequencer register did not take the write");

    // a stray write elsewhere must never disturb stored values
    a_ref_holds: assert property (@(posedge sys_clk) disable iff (!resetn)
        !ref_wen
        |=> $stable(ref_q))
        else $error("reference register changed without a write");

    a_seq_holds: assert property (@(posedge sys_clk) disable iff (!resetn)
        !seq_wen
        |=> $stable(seq_q))
        else $error("sequencer register changed without a write");

    a_ref_read_value: assert property (@(posedge sys_clk) disable iff (!resetn)
        req.rd && req.addr == rscr_pkg::REF_CFG_ADDR
        |=> rdata == $past(ref_q))
        else $error("reference register read returned wrong value");

    a_seq_read_value: assert property (@(posedge sys_clk) disable iff (!resetn)
        req.rd && req.addr == rscr_pkg::SEQ_CFG_ADDR
        |=> rdata == $past(seq_q))
        else $error("sequencer register read returned wrong value");

    // read data must not linger, or a poll could see a stale byte
    a_rdata_idle_zero: assert property (@(posedge sys_clk) disable iff (!resetn)
        !req.rd
        |=> rdata == 8'h00)
        else $error("read data present without a read");

    // ************************************************************
    // decoded controls
    // ************************************************************
    // lead-frame gating shows here; the enable override is checked by a_bypass_blocked
    a_enable_follows: assert property (@(posedge sys_clk) disable iff (!resetn)
        ##1 ctrl.vbuffer_enable_active
            == $past(variant_sync && ref_q[rscr_pkg::VBUF_EN_BIT]))
        else $error("buffer enable control mismatch");

    a_bypass_applied: assert property (@(posedge sys_clk) disable iff (!resetn)
        variant_sync && ref_q[rscr_pkg::BYPASS_BIT] && !ref_q[rscr_pkg::VBUF_EN_BIT]
        |=> ctrl.vbuffer_bypass_active)
        else $error("bypass not applied on chip-scale variant");

    a_boost_off: assert property (@(posedge sys_clk) disable iff (!resetn)
        !ref_q[rscr_pkg::BOOST_BIT]
        |=> !ctrl.vbuffer_boost_active)
        else $error("boost active while its bit is clear");

    a_slot_follows: assert property (@(posedge sys_clk) disable iff (!resetn)
        ##1 ctrl.advanced_slot_count_minus_one
            == $past(seq_q[rscr_pkg::SLOT_MSB:0]))
        else $error("slot field mismatch");

    a_total_follows: assert property (@(posedge sys_clk) disable iff (!resetn)
        ##1 ctrl.advanced_slot_total
            == {1'b0, $past(seq_q[rscr_pkg::SLOT_MSB:0])} + 8'h01)
        else $error("slot total does not follow the stored field");

    // the range code steers analog trims; it must not move between writes
    a_range_held: assert property (@(posedge sys_clk) disable iff (!resetn)
        !ref_wen
        |=> ##1 $stable(ctrl.reference_range))
        else $error("range code moved without a write");

    // flag only reports; picking a valid code stays with software
    a_range_flag_follows: assert property (@(posedge sys_clk) disable iff (!resetn)
        ##1 range_code_invalid
            == ($past(ref_q[rscr_pkg::RANGE_MSB:rscr_pkg::RANGE_LSB]) > rscr_pkg::RANGE_MAX))
        else $error("range code flag mismatch");

    c_ref_write: cover property (@(posedge sys_clk) disable iff (!resetn) ref_wen);
    c_seq_write: cover property (@(posedge sys_clk) disable iff (!resetn) seq_wen);
    c_bypass_on: cover property (@(posedge sys_clk) disable iff (!resetn) ctrl.vbuffer_bypass_active);
    c_bad_range: cover property (@(posedge sys_clk) disable iff (!resetn) range_code_invalid);
    c_slot_full: cover property (@(posedge sys_clk) disable iff (!resetn) ctrl.advanced_slot_total == 8'h80);

endmodule // rscr_regs

// ---- test/test_rscr_regs.sv ----
// self-checking bench for the reference and sequencer configuration registers
// assumes rscr_pkg and the rscr_regs bank are compiled ahead of this file
`timescale 1ns/100ps
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin bad_count++; $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp); end end
module test_rscr_regs;
    // ****************************************
    // signals
    // ****************************************
    logic                 sys_clk;
    logic                 resetn;
    rscr_pkg::rscr_req_t  req;
    logic                 chip_scale_package_variant;
    logic [7:0]           rdata;
    rscr_pkg::rscr_ctrl_t ctrl;
    logic                 range_code_invalid;
    logic [7:0]           ref_m;
    logic [7:0]           seq_m;
    logic [7:0]           exp_rd;
    logic                 var_s1;
    logic                 var_s2;
    logic                 exp_inv;
    rscr_pkg::rscr_ctrl_t exp_ctrl;
    logic [31:0]          seed;
    logic [31:0]          r;
    logic [14:0]          amap [4];
    int                   bad_count;
    int                   total_checks;

    rscr_regs dut_u (
        .sys_clk                    (sys_clk),
        .resetn                     (resetn),
        .req                        (req),
        .rdata                      (rdata),
        .chip_scale_package_variant (chip_scale_package_variant),
        .ctrl                       (ctrl),
        .range_code_invalid         (range_code_invalid)
    );

    // ****************************************
    // expectation helpers
    // ****************************************
    function automatic rscr_pkg::rscr_ctrl_t decode(input logic [7:0] rg, input logic [7:0] sq, input logic v);
        rscr_pkg::rscr_ctrl_t c;
        c.clamp_current_policy            = rg[7];
        c.vbuffer_bypass_active           = v & rg[6] & ~rg[0];
        c.vbuffer_boost_active            = v & rg[5];
        c.vbuffer_enable_active           = v & rg[0];
        c.reference_range                 = rg[4:2];
        c.reference_high_impedance_enable = rg[1];
        c.standard_sequencer_enable       = sq[7];
        c.advanced_slot_count_minus_one   = sq[6:0];
        c.advanced_slot_total             = {1'h0, sq[6:0]} + 8'h01;
        return c;
    endfunction

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // ****************************************
    // reference model and monitor
    // ****************************************
    // model mirrors the two-flop strap path so ctrl can be checked every cycle
    always @(posedge sys_clk or negedge resetn)
        if (!resetn)
        begin
            ref_m    <= 8'h12;
            seq_m    <= 8'h80;
            exp_rd   <= 8'h00;
            var_s1   <= 1'h0;
            var_s2   <= 1'h0;
            exp_ctrl <= decode(8'h12, 8'h80, 1'h0);
            exp_inv  <= 1'h0;
        end
        else
        begin
            if (req.wr && req.addr === 15'h0021) ref_m <= req.wdata;
            if (req.wr && req.addr === 15'h0022) seq_m <= req.wdata;
            exp_rd   <= !req.rd ? 8'h00 : req.addr === 15'h0021 ? ref_m : req.addr === 15'h0022 ? seq_m : 8'h00;
            var_s1   <= chip_scale_package_variant;
            var_s2   <= var_s1;
            exp_ctrl <= decode(ref_m, seq_m, var_s2);
            exp_inv  <= ref_m[4:2] > 3'h4;
        end

    always @(negedge sys_clk)
    begin
        `CHK(rdata, exp_rd)
        `CHK(ctrl, exp_ctrl)
        `CHK(range_code_invalid, exp_inv)
    end

    // ****************************************
    // bus and closing tasks
    // ****************************************
    // one cycle per call; the next call replaces the strobes, so no release edge is needed
    // no single-cycle command select is driven; that bit lives outside this bank
    task automatic bus(input logic w, input logic rd, input logic [14:0] a, input logic [7:0] d);
        req <= '{addr: a, wdata: d, wr: w, rd: rd};
        @(posedge sys_clk);
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ****************************************
    // clock, watchdog, sequence
    // ****************************************
    initial
    begin
        sys_clk = 1'h0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    initial
    begin
        repeat (3000) @(posedge sys_clk);
        bad_count++;
        $display("CHECK FAILED t=%0t watchdog expired", $time);
        stop_test();
    end

    initial
    begin
        req = '0;
        chip_scale_package_variant = 1'h0;
        resetn = 1'h0;
        seed = 32'h0000729B;
        amap = '{15'h0021, 15'h0022, 15'h0020, 15'h0023};
        repeat (8) @(posedge sys_clk);
        resetn <= 1'h1;
        @(posedge sys_clk);
        bus(1'h0, 1'h1, 15'h0021, 8'h00);
        bus(1'h0, 1'h1, 15'h0022, 8'h00);
        bus(1'h0, 1'h0, 15'h0000, 8'h00);
        $display("test reset values done");
        // every range code, valid and not, each read back on the very next cycle
        for (int i = 0; i < 8; i++)
        begin
            bus(1'h1, 1'h0, 15'h0021, {3'h0, 3'(i), 2'h2});
            bus(1'h0, 1'h1, 15'h0021, 8'h00);
        end
        bus(1'h1, 1'h0, 15'h0021, 8'h61);
        bus(1'h0, 1'h1, 15'h0021, 8'h00); // lead-frame: stored and read back, controls stay off
        $display("test range codes done");
        chip_scale_package_variant <= 1'h1;
        repeat (4) bus(1'h0, 1'h0, 15'h0000, 8'h00);
        foreach (amap[k])
        begin
            bus(1'h1, 1'h0, 15'h0021, 8'h41 >> k);
            bus(1'h1, 1'h0, 15'h0021, 8'h61 ^ (8'h01 << k));
            bus(1'h0, 1'h1, 15'h0021, 8'h00);
        end
        bus(1'h1, 1'h0, 15'h0022, 8'h7F);
        bus(1'h0, 1'h1, 15'h0022, 8'h00);
        bus(1'h1, 1'h0, 15'h0022, 8'hFF);
        bus(1'h1, 1'h0, 15'h0022, 8'h00); // slot field back to zero for command modes
        bus(1'h0, 1'h1, 15'h0022, 8'h00);
        $display("test buffer and slot fields done");
        bus(1'h1, 1'h0, 15'h0020, 8'hA5);
        bus(1'h1, 1'h0, 15'h4021, 8'h5A);
        bus(1'h0, 1'h1, 15'h0023, 8'h00);
        bus(1'h0, 1'h1, 15'h0021, 8'h00);
        $display("test unmapped access done");
        repeat (400)
        begin
            r = xs();
            if (r[31:28] == 4'h0) chip_scale_package_variant <= ~chip_scale_package_variant;
            bus(r[2:0] < 3'h3, r[2:0] inside {3'h3, 3'h4, 3'h5}, r[3] ? r[30:16] : amap[r[5:4]], r[15:8]);
        end
        $display("test random traffic done");
        bus(1'h1, 1'h0, 15'h0022, 8'h15);
        resetn <= 1'h0;
        repeat (3) bus(1'h0, 1'h0, 15'h0000, 8'h00);
        resetn <= 1'h1;
        bus(1'h0, 1'h0, 15'h0000, 8'h00);
        bus(1'h0, 1'h1, 15'h0022, 8'h00);
        bus(1'h0, 1'h1, 15'h0021, 8'h00);
        repeat (4) bus(1'h0, 1'h0, 15'h0000, 8'h00);
        $display("test second reset done");
        stop_test();
    end
endmodule // test_rscr_regs
